// >>> rtl/irqc_pkg.sv
// Purpose: constants and types for the interrupt request control block
// Assumes: 8-bit registers reached over a 32-bit Avalon-MM slave, one word per register
// Notes: register byte addresses are word aligned
//
// Summary of operation
// - hardware sets request flags on source events; software writes the enables
// - an accepted enabled request makes the core suspend and service the source
// - the external pin raises its request flag on the selected edge type
// - timer, comparator, time base, low voltage, eeprom and converter sources
// - three primary, three multi-function and one edge select register
// - registers mix enable bits and request flags
// - edge select 00 off, 01 rising, 10 falling, 11 both edges
// - edge select bits 7 to 2 read as zero
// - comparator flag sets on any change of the comparator result bit, wakes device
package irqc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [4:0] IRQC_OFS_EDGE   = 5'h00;
	localparam logic [4:0] IRQC_OFS_PRIA   = 5'h04;
	localparam logic [4:0] IRQC_OFS_PRIB   = 5'h08;
	localparam logic [4:0] IRQC_OFS_PRIC   = 5'h0c;
	localparam logic [4:0] IRQC_OFS_MFA    = 5'h10;
	localparam logic [4:0] IRQC_OFS_MFB    = 5'h14;
	localparam logic [4:0] IRQC_OFS_MFC    = 5'h18;
	localparam logic [4:0] IRQC_OFS_STAT   = 5'h1c;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [1:0] IRQC_EDGE_RST   = 2'h3;
	localparam logic [7:0] IRQC_REG_RST    = 8'h00;
	// ************************************************************
	// edge select encoding
	// ************************************************************
	localparam logic [1:0] IRQC_EDGE_OFF   = 2'h0;
	localparam logic [1:0] IRQC_EDGE_RISE  = 2'h1;
	localparam logic [1:0] IRQC_EDGE_FALL  = 2'h2;
	localparam logic [1:0] IRQC_EDGE_BOTH  = 2'h3;
	// ************************************************************
	// flag positions of the primary and multi-function registers
	// ************************************************************
	localparam logic [7:0] IRQC_PRIA_FLAGS = 8'h70;
	localparam logic [7:0] IRQC_PRIA_MASK  = 8'h7f;
	localparam logic [7:0] IRQC_PRIB_FLAGS = 8'hf0;
	localparam logic [7:0] IRQC_PRIC_FLAGS = 8'h10;
	localparam logic [7:0] IRQC_PRIC_MASK  = 8'h11;
	localparam logic [7:0] IRQC_MFA_FLAGS  = 8'hf0;
	localparam logic [7:0] IRQC_MFB_FLAGS  = 8'h70;
	localparam logic [7:0] IRQC_MFB_MASK   = 8'h77;
	localparam logic [7:0] IRQC_MFC_FLAGS  = 8'h30;
	localparam logic [7:0] IRQC_MFC_MASK   = 8'h33;
	localparam int         IRQC_NSTAT      = 16;

	// event sources, one pulse each
	typedef struct packed {
		logic       timebase0;
		logic       timebase1;
		logic       conv;
		logic       timer0_period;
		logic       timer0_match;
		logic       timer1_period;
		logic       timer1_match;
		logic       timer2_period;
		logic       timer2_match_a;
		logic       timer2_match_b;
		logic       low_volt;
		logic       eeprom;
	} irqc_src_s;

	typedef enum logic [1:0] {
		IRQC_BUS_IDLE,
		IRQC_BUS_ACK
	} irqc_bus_e;
endpackage

// >>> rtl/irqc_top.sv
// Purpose: interrupt request flags, enables, edge select and core request
// Assumes: event inputs are single-cycle pulses on core_clk_in; irq pin is asynchronous
// Notes: every bus access answers one cycle after it is presented
`timescale 1ns/1ns
`default_nettype none
module irqc_top
	import irqc_pkg::*;
#(
	parameter bit HAS_MFB = 1'b1
) (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        clk_en_in,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// event sources
	input  wire logic        ext_irq_pin_in,
	input  wire logic        cmp_result_bit_in,
	input  wire irqc_src_s   src_in,
	// core side
	input  wire logic        core_ack_in,
	output logic             core_irq_out,
	output logic             wake_out,
	output logic             status_irq_out
);
	// ************************************************************
	// state
	// ************************************************************
	logic [1:0]  edge_sel;
	logic [7:0]  pri_a, pri_b, pri_c, mf_a, mf_b, mf_c;
	logic [2:0]  pin_sync;
	logic        cmp_prev;
	logic [15:0] stat, stat_mask;
	irqc_bus_e   bus_st;
	logic [31:0] rdata;

	logic [1:0]  next_edge_sel;
	logic [7:0]  next_pri_a, next_pri_b, next_pri_c, next_mf_a, next_mf_b, next_mf_c;
	logic [2:0]  next_pin_sync;
	logic        next_cmp_prev;
	logic [15:0] next_stat, next_stat_mask;
	irqc_bus_e   next_bus_st;
	logic [31:0] next_rdata;

	logic        wr, rd, pin_rise, pin_fall, pin_evt, cmp_evt, mfa_req, mfb_req, mfc_req;
	logic [7:0]  wbyte, set_a, set_b, set_c, set_ma, set_mb, set_mc;
	logic [15:0] evt;

	// ************************************************************
	// bus decode and events
	// ************************************************************
	assign wr    = avs_write_in && bus_st == IRQC_BUS_IDLE && avs_byteenable_in[0];
	assign rd    = avs_read_in && bus_st == IRQC_BUS_IDLE;
	assign wbyte = avs_writedata_in[7:0];

	assign pin_rise = pin_sync[1] && !pin_sync[2];
	assign pin_fall = !pin_sync[1] && pin_sync[2];
	always_comb begin
		case (edge_sel)
			IRQC_EDGE_RISE: pin_evt = pin_rise;
			IRQC_EDGE_FALL: pin_evt = pin_fall;
			IRQC_EDGE_BOTH: pin_evt = pin_rise || pin_fall;
			default:        pin_evt = 1'b0;
		endcase
	end
	assign cmp_evt = cmp_result_bit_in != cmp_prev;

	// hardware set terms per register; set wins over a software clear
	assign set_a  = {1'b0, mfa_req, cmp_evt, pin_evt, 4'h0};
	assign set_b  = {src_in.timebase0, src_in.conv, mfc_req, mfb_req && HAS_MFB, 4'h0};
	assign set_c  = {3'h0, src_in.timebase1, 4'h0};
	assign set_ma = {src_in.timer1_match, src_in.timer1_period, src_in.timer0_match, src_in.timer0_period, 4'h0};
	assign set_mb = {1'b0, src_in.timer2_match_b, src_in.timer2_match_a, src_in.timer2_period, 4'h0};
	assign set_mc = {2'h0, src_in.eeprom, src_in.low_volt, 4'h0};

	// a multi-function group requests while any enabled sub-flag is set
	assign mfa_req = |(mf_a[7:4] & mf_a[3:0]);
	assign mfb_req = |(mf_b[6:4] & mf_b[2:0]);
	assign mfc_req = |(mf_c[5:4] & mf_c[1:0]);

	// 2+2+3+4+1+2+2 bits: 0 pin, 1 cmp, 2 conv, 3 tb0, 4 tb1, 5-8 mf_a, 9-11 mf_b, 12-13 mf_c
	assign evt = {2'h0, set_mc[5:4], set_mb[6:4], set_ma[7:4], set_c[4], set_b[7:6], set_a[5:4]};

	function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit, input logic [7:0] d,
			input logic [7:0] mask, input logic [7:0] set);
		logic [7:0] v;
		v = hit ? (d & mask) : cur;
		upd = v | (set & mask);
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_pin_sync  = {pin_sync[1:0], ext_irq_pin_in};
		next_cmp_prev  = cmp_result_bit_in;
		next_edge_sel  = (wr && avs_address_in == IRQC_OFS_EDGE) ? wbyte[1:0] : edge_sel;
		next_pri_a = upd(pri_a, wr && avs_address_in == IRQC_OFS_PRIA, wbyte, IRQC_PRIA_MASK, set_a);
		next_pri_b = upd(pri_b, wr && avs_address_in == IRQC_OFS_PRIB, wbyte,
			HAS_MFB ? 8'hff : 8'hee, set_b);
		next_pri_c = upd(pri_c, wr && avs_address_in == IRQC_OFS_PRIC, wbyte, IRQC_PRIC_MASK, set_c);
		next_mf_a  = upd(mf_a, wr && avs_address_in == IRQC_OFS_MFA, wbyte, 8'hff, set_ma);
		next_mf_b  = upd(mf_b, wr && avs_address_in == IRQC_OFS_MFB, wbyte,
			HAS_MFB ? IRQC_MFB_MASK : 8'h00, set_mb);
		next_mf_c  = upd(mf_c, wr && avs_address_in == IRQC_OFS_MFC, wbyte, IRQC_MFC_MASK, set_mc);
		next_stat_mask = (wr && avs_address_in == IRQC_OFS_STAT) ? avs_writedata_in[31:16] : stat_mask;
		next_stat = ((rd && avs_address_in == IRQC_OFS_STAT) ? 16'h0000 : stat) | evt;
		next_bus_st = (avs_read_in || avs_write_in) && bus_st == IRQC_BUS_IDLE ? IRQC_BUS_ACK : IRQC_BUS_IDLE;
		next_rdata  = rdata;
		if (rd) begin
			if (avs_address_in == IRQC_OFS_EDGE) begin
				next_rdata = {30'h0, edge_sel};
			end else if (avs_address_in == IRQC_OFS_PRIA) begin
				next_rdata = {24'h0, pri_a};
			end else if (avs_address_in == IRQC_OFS_PRIB) begin
				next_rdata = {24'h0, pri_b};
			end else if (avs_address_in == IRQC_OFS_PRIC) begin
				next_rdata = {24'h0, pri_c};
			end else if (avs_address_in == IRQC_OFS_MFA) begin
				next_rdata = {24'h0, mf_a};
			end else if (avs_address_in == IRQC_OFS_MFB) begin
				next_rdata = {24'h0, mf_b};
			end else if (avs_address_in == IRQC_OFS_MFC) begin
				next_rdata = {24'h0, mf_c};
			end else if (avs_address_in == IRQC_OFS_STAT) begin
				next_rdata = {stat_mask, stat};
			end else begin
				next_rdata = 32'h0000_0000;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			edge_sel  <= IRQC_EDGE_RST;
			pri_a     <= IRQC_REG_RST;
			pri_b     <= IRQC_REG_RST;
			pri_c     <= IRQC_REG_RST;
			mf_a      <= IRQC_REG_RST;
			mf_b      <= IRQC_REG_RST;
			mf_c      <= IRQC_REG_RST;
			pin_sync  <= 3'h0;
			cmp_prev  <= 1'b0;
			stat      <= 16'h0000;
			stat_mask <= 16'h0000;
			bus_st    <= IRQC_BUS_IDLE;
			rdata     <= 32'h0000_0000;
		end else if (clk_en_in) begin
			edge_sel  <= next_edge_sel;
			pri_a     <= next_pri_a;
			pri_b     <= next_pri_b;
			pri_c     <= next_pri_c;
			mf_a      <= next_mf_a;
			mf_b      <= next_mf_b;
			mf_c      <= next_mf_c;
			pin_sync  <= next_pin_sync;
			cmp_prev  <= next_cmp_prev;
			stat      <= next_stat;
			stat_mask <= next_stat_mask;
			bus_st    <= next_bus_st;
			rdata     <= next_rdata;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	logic any_req;
	assign any_req = |(pri_a[6:4] & pri_a[3:1]) | |(pri_b[7:4] & pri_b[3:0]) | (pri_c[4] & pri_c[0]);
	assign core_irq_out = pri_a[0] && any_req && !core_ack_in;
	assign wake_out = pri_a[5] && pri_a[2];
	assign status_irq_out = |(stat & stat_mask);
	assign avs_readdata_out = rdata;
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && bus_st == IRQC_BUS_IDLE;

	// ************************************************************
	// checks
	// ************************************************************
	a_core_gate: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		core_irq_out |-> pri_a[0]) else $error("core request without global enable");
	a_edge_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		!avs_waitrequest_out && $past(rd) && $past(avs_address_in) == IRQC_OFS_EDGE && $past(clk_en_in)
		|-> avs_readdata_out[31:2] == 30'h0) else $error("edge select upper bits not zero");
	a_pin_rise: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && edge_sel == IRQC_EDGE_RISE && pin_rise |=> pri_a[4]) else $error("rising edge lost");
	a_pin_off: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && edge_sel == IRQC_EDGE_OFF && !pri_a[4] && !(wr && avs_address_in == IRQC_OFS_PRIA)
		|=> !pri_a[4]) else $error("pin flag set while disabled");
	a_cmp_change: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && cmp_evt |=> pri_a[5]) else $error("comparator change lost");
	a_flag_sticky: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && pri_b[6] && !(wr && avs_address_in == IRQC_OFS_PRIB) |=> pri_b[6])
		else $error("converter flag dropped");
	a_src_set: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && src_in.eeprom |=> mf_c[5]) else $error("eeprom event lost");
	a_mf_group: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && mfa_req |=> pri_a[6]) else $error("group flag not raised");
	a_sync_delay: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		clk_en_in && $past(clk_en_in) && $past(clk_en_in, 2) && pin_rise |-> $past(ext_irq_pin_in, 2))
		else $error("pin edge not synchronised");
endmodule
`default_nettype wire

// >>> dv/irqc_partner.sv
// Purpose: event sources, pin, comparator and core acknowledge
// Assumes: all lines change right after a rising edge
// Notes: source lines rest low between pulses; pin, comparator and acknowledge hold their last level
`timescale 1ns/1ns
`default_nettype none
module irqc_partner
	import irqc_pkg::*;
(
	// clock
	input  wire logic     clk_in,
	// far side lines
	output var irqc_src_s src_out,
	output var logic      pin_out,
	output var logic      cmp_out,
	output var logic      ack_out
);
	initial begin
		src_out = '0;
		pin_out = 1'b0;
		cmp_out = 1'b0;
		ack_out = 1'b0;
	end
	// one-cycle event from source idx
	task automatic pulse(input int idx);
		@(posedge clk_in);
		src_out[idx] <= 1'b1;
		@(posedge clk_in);
		src_out <= '0;
		repeat (2) @(posedge clk_in);
	endtask
	// 0 pin, 1 comparator result, 2 core acknowledge
	task automatic set_line(input int which, input logic v);
		@(posedge clk_in);
		case (which)
			0: pin_out <= v;
			1: cmp_out <= v;
			default: ack_out <= v;
		endcase
		repeat (5) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: register and request checks of irqc_top
// Assumes: avalon slave answers after one wait cycle
// Notes: bus answers are taken at the rising edge; level outputs are sampled on the falling edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import irqc_pkg::*;
	logic        clk, rstn, rd_s, wr_s, wreq, irq, wake, sirq, pin, cmp, ack;
	logic [4:0]  addr;
	logic [31:0] wdata, rdata, dump;
	logic [3:0]  be;
	irqc_src_s   src;
	int          errors, n_compared;
	// source index to register and flag
	localparam logic [4:0] TA [12] = '{5'h18, 5'h18, 5'h14, 5'h14, 5'h14, 5'h10, 5'h10, 5'h10, 5'h10,
		5'h08, 5'h0c, 5'h08};
	localparam logic [31:0] TD [12] = '{32'h20, 32'h10, 32'h40, 32'h20, 32'h10, 32'h80, 32'h40, 32'h20,
		32'h10, 32'h40, 32'h10, 32'h80};
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	irqc_top #(.HAS_MFB(1'b1)) dut_u (.core_clk_in(clk), .resetn_in(rstn), .clk_en_in(1'b1),
		.avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.ext_irq_pin_in(pin), .cmp_result_bit_in(cmp), .src_in(src), .core_ack_in(ack),
		.core_irq_out(irq), .wake_out(wake), .status_irq_out(sirq));
	irqc_partner partner_u (.clk_in(clk), .src_out(src), .pin_out(pin), .cmp_out(cmp), .ack_out(ack));
	task automatic complete_run;
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		rd_s <= ~w;
		wr_s <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		n = 0;
		// hold the request until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				errors++;
				complete_run;
			end
		end while (wreq !== 1'b0);
		q = rdata;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf, dump);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask
	// core request, wake and status interrupt together
	task automatic ochk(input logic [2:0] e);
		@(negedge clk);
		chk({29'h0, irq, wake, sirq}, {29'h0, e});
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rstn = 1'b0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		be = 4'hf;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(IRQC_OFS_EDGE, 32'h3);
		for (int i = 1; i < 7; i++) rd_chk(5'(i * 4), 32'h0);
		wr(IRQC_OFS_EDGE, 32'hff);
		rd_chk(IRQC_OFS_EDGE, 32'h3);
		bus(1'b1, IRQC_OFS_EDGE, 32'h0, 4'he, dump);
		rd_chk(IRQC_OFS_EDGE, 32'h3);
		rd_chk(5'h02, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(IRQC_OFS_EDGE, 32'(m));
			wr(IRQC_OFS_PRIA, 32'h0);
			partner_u.set_line(0, 1'b1);
			rd_chk(IRQC_OFS_PRIA, m[0] ? 32'h10 : 32'h0);
			wr(IRQC_OFS_PRIA, 32'h0);
			partner_u.set_line(0, 1'b0);
			rd_chk(IRQC_OFS_PRIA, m[1] ? 32'h10 : 32'h0);
		end
		wr(IRQC_OFS_PRIA, 32'h02);
		partner_u.set_line(0, 1'b1);
		ochk(3'b000);
		wr(IRQC_OFS_PRIA, 32'h13);
		ochk(3'b100);
		wr(IRQC_OFS_PRIA, 32'h11);
		ochk(3'b000);
		rd_chk(IRQC_OFS_PRIA, 32'h11);
		wr(IRQC_OFS_PRIA, 32'h13);
		partner_u.set_line(2, 1'b1);
		ochk(3'b000);
		partner_u.set_line(2, 1'b0);
		wr(IRQC_OFS_PRIA, 32'h03);
		ochk(3'b000);
		wr(IRQC_OFS_PRIA, 32'h04);
		partner_u.set_line(1, 1'b1);
		ochk(3'b010);
		rd_chk(IRQC_OFS_PRIA, 32'h24);
		wr(IRQC_OFS_PRIA, 32'h04);
		partner_u.set_line(1, 1'b0);
		rd_chk(IRQC_OFS_PRIA, 32'h24);
		wr(IRQC_OFS_PRIA, 32'h0);
		for (int i = 0; i < 12; i++) begin
			partner_u.pulse(i);
			rd_chk(TA[i], TD[i]);
			wr(TA[i], 32'h0);
		end
		wr(IRQC_OFS_MFA, 32'h01);
		partner_u.pulse(8);
		rd_chk(IRQC_OFS_PRIA, 32'h40);
		wr(IRQC_OFS_MFA, 32'h0);
		bus(1'b0, IRQC_OFS_STAT, 32'h0, 4'hf, dump);
		partner_u.pulse(9);
		ochk(3'b000);
		wr(IRQC_OFS_STAT, 32'h0004_0000);
		ochk(3'b001);
		rd_chk(IRQC_OFS_STAT, 32'h0004_0004);
		ochk(3'b000);
		complete_run;
	end
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		complete_run;
	end
endmodule
`default_nettype wire
